/* File: hw/cmi_host.sv */
`timescale 1ns/10ps
module cmi_host
	import cmi_pkg::*;
#(
	parameter int GUARD_WAIT_CYCLES = GUARD_CYCLES
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        input_frame_pulse,
	cmi_link_if.host         link
);

	localparam int GW = $clog2(GUARD_WAIT_CYCLES + 1);
	localparam int HW = $clog2(RST_HOLD_CYCLES + 1);

	function automatic cmi_reg_t cmi_decode(input logic [11:0] a);
		case (a)
			OFS_CTRL:   cmi_decode = CMI_REG_CTRL;
			OFS_ACCESS: cmi_decode = CMI_REG_ACCESS;
			OFS_STATUS: cmi_decode = CMI_REG_STATUS;
			OFS_RDATA:  cmi_decode = CMI_REG_RDATA;
			default:    cmi_decode = CMI_REG_NONE;
		endcase
	endfunction

	// ==========================================================
	// device reset sequencing
	logic          fp_meta;
	logic          fp_sync;
	logic          reset_req;
	logic          ode_req;
	logic          rst_pin_n;
	logic [HW-1:0] hold_cnt;
	logic [GW-1:0] guard_cnt;
	logic          release_now;
	logic          ready;

	always_ff @(posedge aclk) begin
		fp_meta <= input_frame_pulse;
		fp_sync <= fp_meta;
	end

	// release only on a frame pulse, clear of the forbidden window
	assign release_now = !rst_pin_n && !reset_req && (hold_cnt == HW'(RST_HOLD_CYCLES)) && fp_sync;
	assign ready       = rst_pin_n && (guard_cnt == '0);

	always_ff @(posedge aclk) begin
		if (!aresetn || rst_pin_n) begin
			hold_cnt <= '0;
		end else if (hold_cnt != HW'(RST_HOLD_CYCLES)) begin
			hold_cnt <= hold_cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || reset_req) begin
			rst_pin_n <= 1'b0;
		end else if (release_now) begin
			rst_pin_n <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			guard_cnt <= '0;
		end else if (release_now) begin
			guard_cnt <= GW'(GUARD_WAIT_CYCLES);
		end else if (guard_cnt != '0) begin
			guard_cnt <= guard_cnt - 1'b1;
		end
	end

	assign link.rst_pin_n       = rst_pin_n;
	assign link.ode_pin         = ode_req && rst_pin_n;
	assign link.jtag_test_reset = 1'b0;

	// ==========================================================
	// AXI4-Lite write channel
	logic        aw_hold;
	logic        w_hold;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_commit;
	cmi_reg_t    wr_reg;
	logic        start_ok;
	cmi_hstate_t hstate;

	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign wr_commit     = aw_hold && w_hold && !s_axi_bvalid;
	assign wr_reg        = cmi_decode(awaddr_q);
	assign start_ok      = ready && (hstate == CMI_HS_IDLE) && (wstrb_q == 4'hF);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			awaddr_q     <= 12'h000;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold  <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold  <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_commit) begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// a refused start or a read-only target answers slverr
				case (wr_reg)
					CMI_REG_CTRL:   s_axi_bresp <= RESP_OKAY;
					CMI_REG_ACCESS: s_axi_bresp <= start_ok ? RESP_OKAY : RESP_SLVERR;
					default:        s_axi_bresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_req <= 1'b1;
			ode_req   <= 1'b0;
		end else if (wr_commit && wr_reg == CMI_REG_CTRL && wstrb_q[0]) begin
			reset_req <= wdata_q[CTRL_RST_BIT];
			ode_req   <= wdata_q[CTRL_ODE_BIT];
		end
	end

	// ==========================================================
	// device processor port master
	logic [15:0] rd_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hstate     <= CMI_HS_IDLE;
			link.cs    <= 1'b0;
			link.wr    <= 1'b0;
			link.addr  <= 15'h0000;
			link.wdata <= 16'h0000;
			rd_q       <= 16'h0000;
		end else begin
			case (hstate)
				CMI_HS_IDLE: begin
					if (wr_commit && wr_reg == CMI_REG_ACCESS && start_ok) begin
						link.cs    <= 1'b1;
						link.wr    <= wdata_q[ACC_WR_BIT];
						link.addr  <= wdata_q[ACC_ADDR_LSB +: 15];
						link.wdata <= wdata_q[15:0];
						hstate     <= CMI_HS_WAIT;
					end
				end
				CMI_HS_WAIT: begin
					// a device put back into reset never answers; give up
					if (link.ack || !rst_pin_n) begin
						link.cs <= 1'b0;
						hstate  <= CMI_HS_IDLE;
						if (link.ack && !link.wr) begin
							rd_q <= link.rdata;
						end
					end
				end
				default: begin
					link.cs <= 1'b0;
					hstate  <= CMI_HS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	cmi_reg_t rd_reg;

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_reg        = cmi_decode(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= (rd_reg == CMI_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
			case (rd_reg)
				CMI_REG_CTRL:   s_axi_rdata <= {30'h0000_0000, ode_req, reset_req};
				CMI_REG_STATUS: s_axi_rdata <= {29'h0000_0000, !rst_pin_n, guard_cnt != '0,
					hstate == CMI_HS_WAIT};
				CMI_REG_RDATA:  s_axi_rdata <= {16'h0000, rd_q};
				default:        s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

/* File: hw/cmi_pkg.sv */
package cmi_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS       = 10;
	localparam int FRAME_CLK_PERIOD_NS = 122;
	localparam int RST_HOLD_NS         = 2 * FRAME_CLK_PERIOD_NS;
	localparam int RST_HOLD_CYCLES     = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GUARD_US            = 250;
	localparam int GUARD_CYCLES        = GUARD_US * 1000 / CLK_PERIOD_NS;

	// ==========================================================
	// connection memories
	localparam int MEM_AW    = 13;
	localparam int MEM_WORDS = 8192;
	localparam logic [MEM_AW-1:0] MEM_LAST = 13'h1FFF;
	localparam int CW_SRC_BIT    = 15;
	localparam int CW_MSG_BIT    = 14;
	localparam int CW_OE_BIT     = 13;
	localparam int CW_PAT_LSB    = 13;
	localparam int CW_STREAM_LSB = 9;
	localparam int CW_CHAN_LSB   = 0;
	localparam int CW_BYTE_LSB   = 0;

	// ==========================================================
	// device processor port
	localparam int PA_MEM_BIT = 14;
	localparam logic [13:0] REG_CR  = 14'h0000;
	localparam logic [13:0] REG_BPR = 14'h0001;
	localparam int CR_MS_LSB    = 0;
	localparam int CR_MBP_BIT   = 3;
	localparam int BPR_BPE_BIT  = 0;
	localparam int BPR_LPAT_LSB = 1;
	localparam int BPR_BPAT_LSB = 4;
	localparam logic [2:0] MS_LOCAL     = 3'h0;
	localparam logic [2:0] MS_BACKPLANE = 3'h1;
	localparam logic [2:0] PAT_RESET    = 3'h0;

	// ==========================================================
	// host AXI4-Lite map
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_ACCESS = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_RDATA  = 12'h00C;
	localparam int CTRL_RST_BIT  = 0;
	localparam int CTRL_ODE_BIT  = 1;
	localparam int ACC_WR_BIT    = 31;
	localparam int ACC_ADDR_LSB  = 16;
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_GUARD_BIT  = 1;
	localparam int ST_RST_BIT    = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CMI_REG_CTRL,
		CMI_REG_ACCESS,
		CMI_REG_STATUS,
		CMI_REG_RDATA,
		CMI_REG_NONE
	} cmi_reg_t;

	typedef enum {CMI_HS_IDLE, CMI_HS_WAIT} cmi_hstate_t;

endpackage

/* File: hw/cmi_link_if.sv */
`timescale 1ns/10ps
interface cmi_link_if;
	logic        cs;
	logic        wr;
	logic [14:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        ack;
	logic        rst_pin_n;
	logic        ode_pin;
	logic        jtag_test_reset;

	modport dev  (input cs, wr, addr, wdata, rst_pin_n, ode_pin, jtag_test_reset, output rdata, ack);
	modport host (output cs, wr, addr, wdata, rst_pin_n, ode_pin, jtag_test_reset, input rdata, ack);
endinterface

/* File: hw/cmi_device.sv */
`timescale 1ns/10ps
// Overview of operation
// - controller holds reset low two frame clocks
// - host waits 250 us before first access
// - reset asserts asynchronously, releases clock-synchronised
// - reset clears registers, outputs high or float
// - reset output state ignores connection word modes
// - release reset away from 12-13 us window
// - output drive stays low until memories programmed
// - keep JTAG test reset low
// - two memories of 8192 sixteen-bit words
// - local memory bit15 high picks local source
// - backplane memory bit15 high picks backplane source
// - connection mode gives stream and channel fields
// - message mode sends low byte
// - message mode words need bit13 set
// - select field 000 local, 001 backplane
// - set mode bit, then block enable
// - block fill puts local pattern in local
// - block fill puts backplane pattern in parallel
// - enable self-clears within 125 us when done
// - clearing enable or mode aborts fill
// - patterns reset to zero and usable
// - reset-select high, bit13 low floats channel
// - address bit14 picks memory, low bits location
module cmi_device
	import cmi_pkg::*;
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	cmi_link_if.dev                     link,
	input  wire logic                   local_reset_state_select,
	input  wire logic                   backplane_reset_state_select,
	input  wire logic [1:0][MEM_AW-1:0] out_addr,
	output logic      [1:0]             out_drive_en_n,
	output logic      [1:0]             out_force_high,
	output logic      [1:0]             out_msg_mode,
	output logic      [1:0][7:0]        out_msg_byte,
	output logic      [1:0]             out_src_local,
	output logic      [1:0][3:0]        out_stream,
	output logic      [1:0][8:0]        out_channel
);

	// ==========================================================
	// reset synchroniser
	logic rst_meta_n;
	logic core_rst_n;

	// pin low clears at once; release waits two edges
	always_ff @(posedge aclk or negedge link.rst_pin_n) begin
		if (!link.rst_pin_n) begin
			rst_meta_n <= 1'b0;
			core_rst_n <= 1'b0;
		end else begin
			rst_meta_n <= aresetn;
			core_rst_n <= rst_meta_n;
		end
	end

	// ==========================================================
	// pin synchronisers: ode, local select, backplane select
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;

	always_ff @(posedge aclk) begin
		pin_meta <= {backplane_reset_state_select, local_reset_state_select, link.ode_pin};
		pin_sync <= pin_meta;
	end

	// ==========================================================
	// processor port decode
	logic [2:0]        memory_select_field;
	logic              block_prog_mode_bit;
	logic              block_prog_enable_bit;
	logic [2:0]        local_block_pattern;
	logic [2:0]        backplane_block_pattern;
	logic [MEM_AW-1:0] fill_addr;
	logic              ack_q;
	logic [15:0]       rdata_q;
	logic              cpu_go;
	logic              is_mem;
	logic              cr_wr;
	logic              bpr_wr;
	logic [1:0]        mem_sel;
	logic [1:0][15:0]  cpu_word;
	logic [1:0][15:0]  out_word;

	assign cpu_go = link.cs && !ack_q;
	assign is_mem = link.addr[PA_MEM_BIT];
	assign cr_wr  = cpu_go && link.wr && !is_mem && (link.addr[13:0] == REG_CR);
	assign bpr_wr = cpu_go && link.wr && !is_mem && (link.addr[13:0] == REG_BPR);
	assign mem_sel[0] = (memory_select_field == MS_LOCAL);
	assign mem_sel[1] = (memory_select_field == MS_BACKPLANE);

	// ==========================================================
	// control and block programming registers
	always_ff @(posedge aclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			memory_select_field     <= MS_LOCAL;
			block_prog_mode_bit     <= 1'b0;
			local_block_pattern     <= PAT_RESET;
			backplane_block_pattern <= PAT_RESET;
		end else begin
			if (cr_wr) begin
				memory_select_field <= link.wdata[CR_MS_LSB +: 3];
				block_prog_mode_bit <= link.wdata[CR_MBP_BIT];
			end
			if (bpr_wr) begin
				local_block_pattern     <= link.wdata[BPR_LPAT_LSB +: 3];
				backplane_block_pattern <= link.wdata[BPR_BPAT_LSB +: 3];
			end
		end
	end

	// a fresh enable write wins over the self-clear of the same cycle
	always_ff @(posedge aclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			block_prog_enable_bit <= 1'b0;
		end else if (cr_wr && !link.wdata[CR_MBP_BIT]) begin
			block_prog_enable_bit <= 1'b0;
		end else if (bpr_wr) begin
			block_prog_enable_bit <= link.wdata[BPR_BPE_BIT] && block_prog_mode_bit;
		end else if (!block_prog_mode_bit) begin
			block_prog_enable_bit <= 1'b0;
		end else if (block_prog_enable_bit && fill_addr == MEM_LAST) begin
			block_prog_enable_bit <= 1'b0;
		end
	end

	// 8192 clocks at 100 MHz is about 82 us, inside the 125 us bound
	always_ff @(posedge aclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			fill_addr <= '0;
		end else if (bpr_wr) begin
			fill_addr <= '0;
		end else if (block_prog_enable_bit) begin
			fill_addr <= fill_addr + 1'b1;
		end
	end

	// ==========================================================
	// connection memories, index 0 local, 1 backplane
	for (genvar g = 0; g < 2; g++) begin : gen_port
		logic [15:0] mem [MEM_WORDS];
		logic [2:0]  pattern;

		assign pattern = (g == 0) ? local_block_pattern : backplane_block_pattern;

		// fill has priority; processor writes are dropped while it runs
		always_ff @(posedge aclk) begin
			if (block_prog_enable_bit) begin
				mem[fill_addr] <= {pattern, 13'h0000};
			end else if (cpu_go && link.wr && is_mem && mem_sel[g]) begin
				mem[link.addr[MEM_AW-1:0]] <= link.wdata;
			end
		end

		assign cpu_word[g] = mem[link.addr[MEM_AW-1:0]];

		always_ff @(posedge aclk) begin
			out_word[g] <= mem[out_addr[g]];
		end
	end

	// ==========================================================
	// processor answer: one-cycle ack after cs is seen
	always_ff @(posedge aclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			ack_q   <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			ack_q <= cpu_go;
			if (cpu_go && !link.wr) begin
				if (is_mem) begin
					rdata_q <= mem_sel[1] ? cpu_word[1] : (mem_sel[0] ? cpu_word[0] : 16'h0000);
				end else if (link.addr[13:0] == REG_CR) begin
					rdata_q <= {12'h000, block_prog_mode_bit, memory_select_field};
				end else if (link.addr[13:0] == REG_BPR) begin
					rdata_q <= {9'h000, backplane_block_pattern, local_block_pattern, block_prog_enable_bit};
				end else begin
					rdata_q <= 16'h0000;
				end
			end
		end
	end

	assign link.ack   = ack_q;
	assign link.rdata = rdata_q;

	// ==========================================================
	// output stream control, priority reset, ode, word enable bit
	function automatic logic [1:0] cmi_out_ctl(
		input logic        in_reset,
		input logic        output_drive_enable_pin,
		input logic        rs_sel,
		input logic [15:0] w
	);
		logic hold;
		hold = in_reset || !output_drive_enable_pin || !w[CW_OE_BIT];
		if (hold) begin
			cmi_out_ctl = rs_sel ? 2'h2 : 2'h1;
		end else begin
			cmi_out_ctl = 2'h0;
		end
	endfunction

	for (genvar g = 0; g < 2; g++) begin : gen_out
		logic rs_sel;
		logic msg;

		assign rs_sel = pin_sync[g + 1];
		assign msg    = out_word[g][CW_MSG_BIT];
		// in reset the word is ignored whatever its mode bits say
		assign {out_drive_en_n[g], out_force_high[g]} =
			cmi_out_ctl(!core_rst_n, pin_sync[0], rs_sel, out_word[g]);
		assign out_msg_mode[g]  = core_rst_n && msg;
		assign out_msg_byte[g]  = msg ? out_word[g][CW_BYTE_LSB +: 8] : 8'h00;
		assign out_src_local[g] = (g == 0) ? out_word[g][CW_SRC_BIT] : !out_word[g][CW_SRC_BIT];
		assign out_stream[g]    = msg ? 4'h0 : out_word[g][CW_STREAM_LSB +: 4];
		assign out_channel[g]   = msg ? 9'h000 : out_word[g][CW_CHAN_LSB +: 9];
	end

endmodule

/* File: testbench/cmi_link_assertions.sv */
`timescale 1ns/10ps
module cmi_link_assertions
	import cmi_pkg::*;
#(
	parameter int GUARD_WAIT_CYCLES = GUARD_CYCLES
)
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        cs,
	input wire logic        wr,
	input wire logic [14:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        ack,
	input wire logic        rst_pin_n,
	input wire logic        ode_pin,
	input wire logic        jtag_test_reset
);
	// ==========================================================
	// pin counters
	// no reset here: a hold that began during aresetn still counts
	int unsigned low_cnt  = 0;
	int unsigned high_cnt = 0;

	always_ff @(posedge aclk) begin
		low_cnt <= rst_pin_n ? 0 : low_cnt + 1;
	end

	always_ff @(posedge aclk) begin
		high_cnt <= rst_pin_n ? high_cnt + 1 : 0;
	end

	// ==========================================================
	// properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_req;
		cs && !ack && rst_pin_n;
	endsequence

	sequence s_ode_off;
		!ode_pin [*8];
	endsequence

	ack_once_a: assert property (ack |=> !ack)
		else $error("ack wider than one cycle");
	ack_cause_a: assert property ($rose(ack) |-> $past(cs) && !$past(ack))
		else $error("ack without a pending request");
	ack_prompt_a: assert property (s_req |=> ack)
		else $error("ack late");
	req_hold_a: assert property (s_req |=> cs && $stable(addr) && $stable(wr) && $stable(wdata))
		else $error("request changed before ack");
	jtag_low_a: assert property (!jtag_test_reset)
		else $error("jtag test reset not low");
	ode_reset_a: assert property ($fell(rst_pin_n) |-> s_ode_off)
		else $error("drive enable high while device reset");
	rst_hold_a: assert property ($rose(rst_pin_n) |-> low_cnt >= RST_HOLD_CYCLES)
		else $error("device reset pulse too short");
	guard_wait_a: assert property ($rose(cs) |-> high_cnt >= GUARD_WAIT_CYCLES)
		else $error("access inside guard time");
endmodule

/* File: testbench/connection_memory_init_control_tb.sv */
`timescale 1ns/10ps
module connection_memory_init_control_tb
	import cmi_pkg::*;
;
	localparam int             GUARD = 20;
	localparam logic [12:0]    IDX   = 13'h0a07;
	localparam logic [14:0]    A_CR  = {1'h0, REG_CR};
	localparam logic [14:0]    A_BPR = {1'h0, REG_BPR};
	localparam logic [14:0]    A_MEM = {2'h2, IDX};
	logic                      aclk;
	logic                      aresetn;
	logic [11:0]               s_axi_awaddr;
	logic                      s_axi_awvalid;
	logic                      s_axi_awready;
	logic [31:0]               s_axi_wdata;
	logic [3:0]                s_axi_wstrb;
	logic                      s_axi_wvalid;
	logic                      s_axi_wready;
	logic [1:0]                s_axi_bresp;
	logic                      s_axi_bvalid;
	logic                      s_axi_bready;
	logic [11:0]               s_axi_araddr;
	logic                      s_axi_arvalid;
	logic                      s_axi_arready;
	logic [31:0]               s_axi_rdata;
	logic [1:0]                s_axi_rresp;
	logic                      s_axi_rvalid;
	logic                      s_axi_rready;
	logic                      input_frame_pulse;
	logic                      local_reset_state_select;
	logic                      backplane_reset_state_select;
	logic [1:0][MEM_AW-1:0]    out_addr;
	logic [1:0]                out_drive_en_n;
	logic [1:0]                out_force_high;
	logic [1:0]                out_msg_mode;
	logic [1:0][7:0]           out_msg_byte;
	logic [1:0]                out_src_local;
	logic [1:0][3:0]           out_stream;
	logic [1:0][8:0]           out_channel;
	logic [31:0]               rw;
	logic [1:0]                resp;
	logic [15:0]               rd;
	logic [2:0]                lp;
	logic [2:0]                bp;
	logic [12:0]               ix [3];
	time                       t0;
	int                        n_mismatch = 0;
	int                        n_compared = 0;

	cmi_link_if link();

	cmi_host #(.GUARD_WAIT_CYCLES(GUARD)) i_cmi_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .input_frame_pulse, .link(link));

	cmi_device i_cmi_device (.aclk, .aresetn, .link(link), .local_reset_state_select,
		.backplane_reset_state_select, .out_addr, .out_drive_en_n, .out_force_high, .out_msg_mode,
		.out_msg_byte, .out_src_local, .out_stream, .out_channel);

	cmi_link_assertions #(.GUARD_WAIT_CYCLES(GUARD)) i_cmi_link_assertions (.aclk, .aresetn, .cs(link.cs),
		.wr(link.wr), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
		.rst_pin_n(link.rst_pin_n), .ode_pin(link.ode_pin), .jtag_test_reset(link.jtag_test_reset));

	// ==========================================================
	// clock and frame pulse
	initial begin
		aclk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
	end

	always begin
		repeat (63) @(posedge aclk);
		input_frame_pulse <= 1'b1;
		@(posedge aclk);
		input_frame_pulse <= 1'b0;
	end

	// ==========================================================
	// helpers
	task automatic results;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// handshakes are judged at the falling edge, where every channel is settled
	task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d);
		logic ah;
		logic wh;
		logic dh;
		int   n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		dh = 1'b0;
		n = 0;
		while (!dh && n < 100) begin
			@(negedge aclk);
			ah = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
			wh = s_axi_wvalid && s_axi_wready;
			dh = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
			resp = wr ? s_axi_bresp : s_axi_rresp;
			rw = s_axi_rdata;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (ah) s_axi_arvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (!dh) chk(32'h0000_0000, 32'h0000_0001, "axi stall");
	endtask

	task automatic wr32(input logic [11:0] a, input logic [31:0] d);
		axi(1'b1, a, d);
		chk(resp, RESP_OKAY, "bresp");
	endtask

	task automatic wait_st(input logic [2:0] m);
		int n;
		n = 0;
		do begin
			axi(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end while ((rw[2:0] & m) !== 3'h0 && n < 100);
		chk(rw[2:0] & m, 32'h0000_0000, "status idle");
	endtask

	task automatic dev(input logic wr, input logic [14:0] a, input logic [15:0] d);
		wr32(OFS_ACCESS, {wr, a, d});
		wait_st(3'h1);
		axi(1'b0, OFS_RDATA, 32'h0000_0000);
		rd = rw[15:0];
	endtask

	// ==========================================================
	// tests
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		input_frame_pulse = 1'b0;
		local_reset_state_select = 1'b1;
		backplane_reset_state_select = 1'b0;
		out_addr = '0;
		ix = '{13'h0000, IDX, MEM_LAST};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axi(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rw[ST_RST_BIT], 32'h0000_0001, "device held");
		chk({out_drive_en_n, out_force_high}, 32'h0000_0006, "reset outputs");
		axi(1'b1, OFS_STATUS, 32'h0000_0000);
		chk(resp, RESP_SLVERR, "status write refused");
		axi(1'b0, 12'h010, 32'h0000_0000);
		chk(resp, RESP_SLVERR, "unmapped read");
		wr32(OFS_CTRL, 32'h0000_0000);
		wait_st(3'h7);
		chk({out_drive_en_n, out_force_high}, 32'h0000_0006, "drive off");
		$display("test reset done");
		dev(1'b1, A_CR, 16'h0000);
		dev(1'b1, A_MEM, 16'h872c);
		dev(1'b1, A_CR, 16'h0001);
		dev(1'b1, A_MEM, 16'hb211);
		dev(1'b0, A_MEM, 16'h0000);
		chk(rd, 16'hb211, "backplane word");
		dev(1'b1, A_CR, 16'h0002);
		dev(1'b0, A_MEM, 16'h0000);
		chk(rd, 16'h0000, "no memory selected");
		dev(1'b1, A_CR, 16'h0000);
		dev(1'b0, A_MEM, 16'h0000);
		chk(rd, 16'h872c, "local word");
		wr32(OFS_CTRL, 32'h0000_0002);
		out_addr <= {IDX, IDX};
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		chk(out_src_local, 32'h0000_0001, "source");
		chk({out_stream, out_channel}, {4'h9, 4'h3, 9'h011, 9'h12c}, "stream chan");
		chk({out_drive_en_n, out_force_high}, 32'h0000_0004, "per channel drive");
		dev(1'b1, A_MEM, 16'h60a5);
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		chk({out_msg_mode, out_msg_byte, out_drive_en_n[0]}, {2'h1, 8'h00, 8'ha5, 1'h0}, "message");
		$display("test access done");
		for (int p = 0; p < 2; p++) begin
			lp = p ? 3'h5 : 3'h0;
			bp = p ? 3'h3 : 3'h0;
			dev(1'b1, A_CR, 16'h0008);
			dev(1'b1, A_BPR, {9'h000, bp, lp, 1'h1});
			t0 = $time;
			do dev(1'b0, A_BPR, 16'h0000); while (rd[0] !== 1'b0 && $time - t0 < 130000);
			chk({rd[0], $time - t0 <= 125000}, 32'h0000_0001, "fill time");
			for (int m = 0; m < 2; m++) begin
				dev(1'b1, A_CR, {12'h000, 1'h1, 3'(m)});
				for (int k = 0; k < 3; k++) begin
					dev(1'b0, {2'h2, ix[k]}, 16'h0000);
					chk(rd, {m ? bp : lp, 13'h0000}, "fill word");
				end
			end
		end
		for (int p = 0; p < 2; p++) begin
			dev(1'b1, A_CR, 16'h0000);
			dev(1'b1, {2'h2, MEM_LAST}, 16'h1234);
			dev(1'b1, A_CR, 16'h0008);
			dev(1'b1, A_BPR, 16'h000b);
			dev(1'b1, p ? A_CR : A_BPR, 16'h0000);
			dev(1'b0, A_BPR, 16'h0000);
			chk(rd[0], 1'b0, "abort clears enable");
			// a fill that kept running would reach the tail word within this wait
			repeat (MEM_WORDS) @(posedge aclk);
			dev(1'b1, A_CR, 16'h0000);
			dev(1'b0, {2'h2, MEM_LAST}, 16'h0000);
			chk(rd, 16'h1234, "abort keeps tail");
		end
		$display("test fill done");
		dev(1'b1, A_CR, 16'h0009);
		wr32(OFS_CTRL, 32'h0000_0003);
		@(negedge aclk);
		chk({out_drive_en_n, out_force_high}, 32'h0000_0006, "reset over words");
		wr32(OFS_CTRL, 32'h0000_0000);
		wait_st(3'h7);
		dev(1'b0, A_CR, 16'h0000);
		chk(rd, 16'h0000, "control default");
		dev(1'b0, A_BPR, 16'h0000);
		chk(rd, 16'h0000, "pattern default");
		$display("test rerun done");
		results;
	end

	initial begin
		#(60000 * CLK_PERIOD_NS);
		n_mismatch++;
		$display("FAIL %0t watchdog expired", $time);
		results;
	end
endmodule
